/* File: src/seq_timing_pkg.sv */
// Package: op codes, word layout, timing constants and carriers
`default_nettype none
package seq_timing_pkg;
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned TICK_NS = 1000;
	localparam int unsigned CLK_NS = 1000 / CLK_MHZ;
	localparam int unsigned TICK_CYCLES = TICK_NS / CLK_NS;
	localparam int TICK_W = 8;
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

	localparam logic [3:0] OP_HALT = 4'h7;
	localparam logic [3:0] OP_DELAY = 4'h8;
	localparam logic [3:0] OP_WAIT_FRAME = 4'h9;
	localparam logic [3:0] OP_CMP_FRAME = 4'hA;
	localparam logic [3:0] OP_CMP_MSG = 4'hB;
	localparam logic [4:0] FIXED_PATTERN = 5'h0A;

	localparam int OPC_LSB = 0;
	localparam int OPC_MSB = 3;
	localparam int COND_LSB = 10;
	localparam int COND_MSB = 14;
	localparam int FIX_LSB = 5;
	localparam int FIX_MSB = 9;
	localparam int COND_W = 5;
	localparam logic [15:0] ZERO16 = 16'h0000;
	localparam logic [15:0] ONE16 = 16'h0001;

	typedef struct packed {
		logic [15:0] op_word;
		logic [15:0] param;
	} instr_t;

	typedef struct packed {
		logic less_than_flag;
		logic equal_flag;
	} cmp_flags_t;
endpackage : seq_timing_pkg
`default_nettype wire

/* File: src/us_tick_gen.sv */
// One-microsecond tick from the controller clock
`default_nettype none
module us_tick_gen (
	input wire logic clk,
	input wire logic resetn,
	output logic tick
);
	logic [seq_timing_pkg::TICK_W-1:0] cnt_q;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= '0;
			tick <= 1'b0;
		end else if (cnt_q == seq_timing_pkg::TICK_LAST) begin
			cnt_q <= '0;
			tick <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 1'b1;
			tick <= 1'b0;
		end
	end
endmodule : us_tick_gen
`default_nettype wire

/* File: src/bc_sequencer_timing_ops.sv */
// Sequencer executing halt, delay, frame wait and timer compare instructions
`default_nettype none
module bc_sequencer_timing_ops (
	input wire logic clk,
	input wire logic resetn,
	input wire logic start,
	input wire logic [15:0] frame_time_load,
	output logic fetch_req,
	input wire logic fetch_valid,
	input wire seq_timing_pkg::instr_t fetch_instr,
	input wire logic [seq_timing_pkg::COND_W-1:0] cond_true,
	output logic running,
	output logic trapped,
	output logic less_than_flag,
	output logic equal_flag,
	output logic [15:0] frame_time,
	output logic [15:0] msg_time
);
	typedef enum logic [4:0] {
		S_IDLE = 5'b00001,
		S_FETCH = 5'b00010,
		S_DELAY = 5'b00100,
		S_WAIT_FRAME = 5'b01000,
		S_TRAP = 5'b10000
	} state_t;

	state_t state_q, state_d;
	logic tick;
	logic [2:0] start_sync_q;
	logic start_seen_q;
	logic start_pulse;
	logic [15:0] op_word;
	logic [15:0] param;
	logic [3:0] opc;
	logic cond_ok;
	logic word_ok;
	logic take;
	logic delay_load;

	// Unsigned 16-bit compare, both flags formed at once
	function automatic seq_timing_pkg::cmp_flags_t cmp16(
		input logic [15:0] p,
		input logic [15:0] cnt
	);
		seq_timing_pkg::cmp_flags_t r;
		r.less_than_flag = (p < cnt);
		r.equal_flag = (p == cnt);
		return r;
	endfunction : cmp16

	us_tick_gen u_tick (
		.clk(clk),
		.resetn(resetn),
		.tick(tick)
	);

	// Start may come from host-side logic outside this clock
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			start_sync_q <= 3'h0;
			start_seen_q <= 1'b0;
		end else begin
			start_sync_q <= {start_sync_q[1:0], start};
			if (start_sync_q[2] == start_sync_q[1]) begin
				start_seen_q <= start_sync_q[1];
			end
		end
	end
	assign start_pulse = (start_sync_q[2] == start_sync_q[1]) &&
		start_sync_q[1] && !start_seen_q;

	assign op_word = fetch_instr.op_word;
	assign param = fetch_instr.param;
	assign opc = op_word[seq_timing_pkg::OPC_MSB:seq_timing_pkg::OPC_LSB];
	assign take = (state_q == S_FETCH) && fetch_valid;

	// Condition field selects one condition line; unknown selects fail
	always_comb begin
		cond_ok = 1'b0;
		if (op_word[seq_timing_pkg::COND_MSB:seq_timing_pkg::COND_LSB] <
			5'(seq_timing_pkg::COND_W)) begin
			cond_ok = cond_true[op_word[seq_timing_pkg::COND_MSB -
				2:seq_timing_pkg::COND_LSB]];
		end
	end

	always_comb begin
		word_ok = (^op_word) &&
			(op_word[seq_timing_pkg::FIX_MSB:seq_timing_pkg::FIX_LSB] ==
			seq_timing_pkg::FIXED_PATTERN) &&
			(op_word[seq_timing_pkg::FIX_LSB-1:seq_timing_pkg::OPC_MSB+1]
			== 1'b0) &&
			(opc inside {seq_timing_pkg::OP_HALT, seq_timing_pkg::OP_DELAY,
			seq_timing_pkg::OP_WAIT_FRAME, seq_timing_pkg::OP_CMP_FRAME,
			seq_timing_pkg::OP_CMP_MSG});
	end

	assign delay_load = take && word_ok && (opc == seq_timing_pkg::OP_DELAY)
		&& cond_ok && (param != seq_timing_pkg::ZERO16);

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			S_IDLE: begin
				if (start_pulse) begin
					state_d = S_FETCH;
				end
			end
			S_FETCH: begin
				if (fetch_valid) begin
					if (!word_ok) begin
						state_d = S_TRAP;
					end else if (opc == seq_timing_pkg::OP_HALT && cond_ok) begin
						state_d = S_IDLE;
					end else if (delay_load) begin
						state_d = S_DELAY;
					end else if (opc == seq_timing_pkg::OP_WAIT_FRAME &&
						cond_ok && frame_time != seq_timing_pkg::ZERO16) begin
						state_d = S_WAIT_FRAME;
					end
					// False condition falls through to next fetch
				end
			end
			S_DELAY: begin
				if (tick && msg_time == seq_timing_pkg::ONE16) begin
					state_d = S_FETCH;
				end
			end
			S_WAIT_FRAME: begin
				if (frame_time == seq_timing_pkg::ZERO16) begin
					state_d = S_FETCH;
				end
			end
			S_TRAP: begin
				if (start_pulse) begin
					state_d = S_FETCH;
				end
			end
			default: begin
				state_d = S_TRAP;
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= S_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Only the next-word request and status views of the state
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			fetch_req <= 1'b0;
			running <= 1'b0;
			trapped <= 1'b0;
		end else begin
			fetch_req <= (state_d == S_FETCH);
			running <= (state_d != S_IDLE) && (state_d != S_TRAP);
			trapped <= (state_d == S_TRAP);
		end
	end

	// Delay reuses the message timer instead of a private counter
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			msg_time <= seq_timing_pkg::ZERO16;
		end else if (delay_load) begin
			msg_time <= param;
		end else if (tick && msg_time != seq_timing_pkg::ZERO16) begin
			msg_time <= msg_time - seq_timing_pkg::ONE16;
		end
	end

	// Frame counter reloads on start, counts down per microsecond
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			frame_time <= seq_timing_pkg::ZERO16;
		end else if (start_pulse) begin
			frame_time <= frame_time_load;
		end else if (tick && frame_time != seq_timing_pkg::ZERO16) begin
			frame_time <= frame_time - seq_timing_pkg::ONE16;
		end
	end

	// Compares ignore the condition field
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			less_than_flag <= 1'b0;
			equal_flag <= 1'b0;
		end else if (take && word_ok) begin
			if (opc == seq_timing_pkg::OP_CMP_FRAME) begin
				{less_than_flag, equal_flag} <= cmp16(param, frame_time);
			end else if (opc == seq_timing_pkg::OP_CMP_MSG) begin
				{less_than_flag, equal_flag} <= cmp16(param, msg_time);
			end
		end
	end
endmodule : bc_sequencer_timing_ops
`default_nettype wire

/* File: testbench/seq_timing_props.sv */
// Checker for the sequencer timing instructions
`default_nettype none
module seq_timing_props (
	input wire logic clk,
	input wire logic resetn,
	input wire logic fetch_req,
	input wire logic fetch_valid,
	input wire seq_timing_pkg::instr_t fetch_instr,
	input wire logic [4:0] cond_true,
	input wire logic running,
	input wire logic trapped,
	input wire logic less_than_flag,
	input wire logic equal_flag,
	input wire logic [15:0] frame_time,
	input wire logic [15:0] msg_time
);
	logic [15:0] w, p;
	logic tk, g, ok, ct, cf, cm;
	assign w = fetch_instr.op_word;
	assign p = fetch_instr.param;
	assign tk = fetch_req && fetch_valid;
	assign ct = w[14:10] < 5'h05 && cond_true[w[12:10]];
	assign g = ^w && w[9:4] == 6'h14 && w[3:0] > 4'h6 && w[3:0] < 4'hC;
	assign ok = tk && g;
	assign cf = ok && w[3:0] == 4'hA;
	assign cm = ok && w[3:0] == 4'hB;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!resetn);
	chk_frame_below: assert property (cf && p < frame_time |=> less_than_flag && !equal_flag)
		else $error("frame compare below wrong");
	chk_frame_equal: assert property (cf && p == frame_time |=> equal_flag && !less_than_flag)
		else $error("frame compare equal wrong");
	chk_frame_above: assert property (cf && p > frame_time |=> !less_than_flag && !equal_flag)
		else $error("frame compare above wrong");
	chk_msg_below: assert property (cm && p < msg_time |=> less_than_flag && !equal_flag)
		else $error("message compare below wrong");
	chk_msg_equal: assert property (cm && p == msg_time |=> equal_flag && !less_than_flag)
		else $error("message compare equal wrong");
	chk_msg_above: assert property (cm && p > msg_time |=> !less_than_flag && !equal_flag)
		else $error("message compare above wrong");
	chk_bad_word: assert property (tk && !g |=> trapped && !fetch_req)
		else $error("bad word not trapped");
	chk_delay_load: assert property (ok && w[3:0] == 4'h8 && ct && p != 16'h0000 |=> msg_time == $past(p) && !fetch_req)
		else $error("delay did not load timer");
	chk_skip_wait: assert property (ok && (w[3:0] == 4'h8 || w[3:0] == 4'h9) && !ct |-> ##[1:2] fetch_req)
		else $error("false wait stalled");
	chk_halt_stop: assert property (ok && w[3:0] == 4'h7 && ct |=> !running && !fetch_req)
		else $error("halt did not stop");
	cov_delay: cover property (ok && w[3:0] == 4'h8 && ct);
	cov_trap: cover property ($rose(trapped));
	cov_msg_eq: cover property (cm && p == msg_time);
endmodule : seq_timing_props
bind bc_sequencer_timing_ops seq_timing_props i_seq_timing_props (.*);
`default_nettype wire

/* File: testbench/host_feed.sv */
// Host-side model that hands instruction words to the sequencer
`default_nettype none
module host_feed (
	input wire logic clk,
	input wire logic fetch_req,
	input wire logic send,
	input wire seq_timing_pkg::instr_t instr,
	output logic fetch_valid,
	output seq_timing_pkg::instr_t fetch_instr
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		fetch_valid = 1'b0;
		fetch_instr = '0;
	end
	// Idle bus flips each cycle so a stale word never looks valid
	always @(negedge clk) begin
		fetch_valid <= send && fetch_req;
		fetch_instr <= (send && fetch_req) ? instr : ~fetch_instr;
	end
endmodule : host_feed
`default_nettype wire

/* File: testbench/bc_sequencer_timing_ops_bench.sv */
// Bench for the sequencer timing instructions
`default_nettype none
module bc_sequencer_timing_ops_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, resetn, start, fetch_req, fetch_valid, running, trapped;
	logic less_than_flag, equal_flag, send;
	logic [15:0] frame_time_load, frame_time, msg_time;
	logic [4:0] cond_true;
	seq_timing_pkg::instr_t fetch_instr, instr;
	int err_count, checks_done, n;
	time t0;
	// Row: op, param, less-than, equal
	logic [21:0] rows [5] = '{{4'hA, 16'h0000, 2'h2}, {4'hA, 16'h8000, 2'h0},
		{4'hB, 16'h0000, 2'h1}, {4'hA, 16'hFFFF, 2'h0}, {4'hB, 16'hFFFF, 2'h0}};
	bc_sequencer_timing_ops i_bc_sequencer_timing_ops (.*);
	host_feed i_host_feed (.*);
	task automatic complete_run();
		if (err_count == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : complete_run
	task automatic cmp(string nm, logic [15:0] e, logic [15:0] s);
		checks_done++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask : cmp
	function automatic logic [15:0] wd(logic [3:0] op, logic [4:0] c);
		logic [15:0] w;
		w = {1'b0, c, 5'h0A, 1'b0, op};
		w[15] = ~^w;
		return w;
	endfunction : wd
	// Returns at the falling edge after the word was taken
	task automatic issue(logic [15:0] w, logic [15:0] p);
		instr = {w, p};
		send = 1'b1;
		n = 0;
		do @(posedge clk); while (!(fetch_req && fetch_valid) && ++n < 3000);
		if (n >= 3000) begin
			err_count++;
			complete_run();
		end
		send <= 1'b0;
		@(negedge clk);
	endtask : issue
	task automatic pulse_start();
		start = 1'b1;
		repeat (4) @(negedge clk);
		start = 1'b0;
	endtask : pulse_start
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		{resetn, start, send, err_count, checks_done} = '0;
		instr = '0;
		frame_time_load = 16'h0003;
		cond_true = 5'h01;
		repeat (10) @(negedge clk);
		cmp("running", 1'h0, running);
		resetn = 1'b1;
		pulse_start();
		foreach (rows[i]) begin
			issue(wd(rows[i][21:18], 5'h00), rows[i][17:2]);
			cmp("lt", rows[i][1], less_than_flag);
			cmp("eq", rows[i][0], equal_flag);
		end
		issue(wd(4'h8, 5'h01), 16'h0005);
		cmp("req", 1'h1, fetch_req);
		issue(wd(4'h9, 5'h01), 16'h0000);
		cmp("req", 1'h1, fetch_req);
		issue(wd(4'h9, 5'h00), 16'h0000);
		issue(wd(4'hA, 5'h00), 16'h0000);
		cmp("frame", 16'h0000, frame_time);
		cmp("eq", 1'h1, equal_flag);
		issue(wd(4'h8, 5'h00), 16'h0002);
		cmp("msg", 16'h0002, msg_time);
		t0 = $time;
		issue(wd(4'hB, 5'h00), 16'h0000);
		cmp("wait", 1'h1, $time - t0 >= 1000 && $time - t0 <= 2100);
		issue(wd(4'h7, 5'h01), 16'h0000);
		cmp("req", 1'h1, fetch_req);
		issue(wd(4'h7, 5'h00), 16'h0000);
		repeat (20) @(negedge clk);
		cmp("running", 1'h0, running);
		cmp("req", 1'h0, fetch_req);
		pulse_start();
		issue(wd(4'hA, 5'h00) ^ 16'h8000, 16'h0000);
		cmp("trap", 1'h1, trapped);
		complete_run();
	end
endmodule : bc_sequencer_timing_ops_bench
`default_nettype wire
